// [design/ftpm_params.svh]
// Constants for the fan tach period monitor: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design modules and the bench files.
`ifndef FTPM_PARAMS_SVH
`define FTPM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FTPM_OFS_CONFIG      8'h00
`define FTPM_OFS_DIVISOR     8'h05
`define FTPM_OFS_FAN1_READ   8'h28
`define FTPM_OFS_FAN2_READ   8'h29
`define FTPM_OFS_FAN1_LIMIT  8'h3c
`define FTPM_OFS_FAN2_LIMIT  8'h3d

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FTPM_RST_CONFIG      8'h08
`define FTPM_RST_DIVISOR     8'h14
`define FTPM_RST_READ        8'h00
`define FTPM_RST_LIMIT       8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FTPM_CFG_START_BIT   0
`define FTPM_CFG_INTCLR_BIT  3
`define FTPM_CFG_INIT_BIT    7
`define FTPM_DIV1_LSB        2
`define FTPM_DIV2_LSB        4

// ----------------------------------------------------------------------------
// Timing: internal time base derived from the system clock
// ----------------------------------------------------------------------------
`define FTPM_CLK_HZ          125000000
`define FTPM_OSC_HZ          22500
`define FTPM_BASE_DIV        (`FTPM_CLK_HZ / `FTPM_OSC_HZ)
`define FTPM_COUNT_FULL      8'hff

`endif

// [design/ftpm_pkg.sv]
// Types shared by the fan tach period monitor modules.
// Assumes the constants header is on the include path.
package ftpm_pkg;
    typedef logic [7:0] ftpm_addr_t;
    typedef logic [7:0] ftpm_byte_t;
    typedef logic [1:0] ftpm_divsel_t;

    // Measurement engine states
    typedef enum logic [1:0] {CNT_IDLE, CNT_ARM, CNT_RUN} ftpm_cnt_state_e;

    // Fan sequencer states
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FAN1, SEQ_FAN2} ftpm_seq_state_e;
endpackage : ftpm_pkg

// [design/ftpm_meas_if.sv]
// Link between the fan sequencer and the period measurement engine.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface ftpm_meas_if;
    logic                start;     // One-cycle pulse: begin a measurement
    logic                abort;     // Level: monitoring halted
    logic                tachLevel; // Selected fan tach level
    logic                tick;      // Prescaled time-base pulse
    logic                done;      // One-cycle pulse: count is valid
    logic                busy;      // Measurement in progress
    ftpm_pkg::ftpm_byte_t count;    // Running tick count; holds the result after done

    modport seq (output start, output abort, output tachLevel, output tick,
                 input done, input busy, input count);
    modport counter (input start, input abort, input tachLevel, input tick,
                     output done, output busy, output count);
endinterface : ftpm_meas_if

// [design/ftpm_period_counter.sv]
// Period measurement engine: counts time-base ticks between a tach rising
// edge and the second rising edge after it, saturating at full scale.
// Assumes the tach level is synchronous to sys_clk.
`timescale 1ns/1ps
`include "ftpm_params.svh"
module ftpm_period_counter (
    input  wire logic      sys_clk,
    input  wire logic      rst,
    ftpm_meas_if.counter   meas
);
    import ftpm_pkg::*;

    typedef struct packed {
        ftpm_cnt_state_e state;
        logic            edges;
        logic            tachPrev;
        ftpm_byte_t      count;
        logic            done;
    } ftpm_cnt_s;

    ftpm_cnt_s st_reg;
    ftpm_cnt_s st_next;
    logic      rise;

    assign rise       = meas.tachLevel & ~st_reg.tachPrev;
    assign meas.done  = st_reg.done;
    assign meas.count = st_reg.count;
    assign meas.busy  = (st_reg.state != CNT_IDLE);

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.done     = 1'b0;
        st_next.tachPrev = meas.tachLevel;
        if (meas.abort) begin
            st_next.state = CNT_IDLE;
        end else begin
            unique case (st_reg.state)
                CNT_IDLE: begin
                    if (meas.start) begin
                        st_next.state = CNT_ARM;
                    end
                end
                CNT_ARM: begin
                    if (rise) begin
                        st_next.state = CNT_RUN;
                        st_next.edges = 1'b0;
                        st_next.count = 8'h00;
                    end
                end
                CNT_RUN: begin
                    if (rise && st_reg.edges) begin
                        st_next.done  = 1'b1;
                        st_next.state = CNT_IDLE;
                    end else if (st_reg.count == `FTPM_COUNT_FULL) begin
                        st_next.done  = 1'b1;
                        st_next.state = CNT_IDLE;
                    end else begin
                        if (rise) begin
                            st_next.edges = 1'b1;
                        end
                        if (meas.tick) begin
                            st_next.count = st_reg.count + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{state: CNT_IDLE, edges: 1'b0, tachPrev: 1'b0,
                        count: 8'h00, done: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : ftpm_period_counter

// [design/ftpm_fan_tach_monitor.sv]
// Fan tach period monitor: registers, time base, prescaler, fan sequencer
// and low-speed limit comparison for two fans.
// Assumes a simple synchronous register port from the serial interface and
// tach inputs already conditioned and synchronous to sys_clk.
//
// Summary of operation
// - Fan measuring starts with monitoring start, unsynchronised to analog work.
// - Each measurement spans two tach periods, three rising edges.
// - Count 22.5 kHz time-base ticks in an 8-bit counter over window.
// - Window opens at a rising edge, closes at second following one.
// - Fans are measured one after the other, never together.
// - Measurement also ends when counter reaches full scale.
// - Completed count goes to that fan's reading register, readable anytime.
// - Readings refresh while monitoring runs; updates stop when halted.
// - Prescaler divides time base by 1, 2, 4 or 8.
// - Prescaler setting resets to divide by two.
// - Count equals base frequency times sixty over rpm times divisor.
// - Each fan has one low-speed limit, a maximum count.
// - Alarm when a completed count exceeds that fan's limit.
`timescale 1ns/1ps
`include "ftpm_params.svh"
module ftpm_fan_tach_monitor #(
    parameter int unsigned BASE_DIV = `FTPM_BASE_DIV
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 fan_one_pulse_input,
    input  wire logic                 fan_two_pulse_input,
    input  wire logic                 regWrEn,
    input  wire logic                 regRdEn,
    input  wire ftpm_pkg::ftpm_addr_t regAddr,
    input  wire ftpm_pkg::ftpm_byte_t regWrData,
    output ftpm_pkg::ftpm_byte_t      regRdData,
    output logic                      fanOneAlarm,
    output logic                      fanTwoAlarm,
    output logic                      monitorActive
);
    import ftpm_pkg::*;

    typedef struct packed {
        ftpm_byte_t      cfg;
        ftpm_byte_t      divCfg;
        ftpm_byte_t      read1;
        ftpm_byte_t      read2;
        ftpm_byte_t      limit1;
        ftpm_byte_t      limit2;
        logic [1:0]      alarm;
        ftpm_seq_state_e state;
        logic [12:0]     baseCnt;
        logic [2:0]      preCnt;
        logic            startPulse;
        ftpm_byte_t      rdData;
    } ftpm_mon_s;

    ftpm_mon_s st_reg;
    ftpm_mon_s st_next;

    ftpm_meas_if meas ();

    logic         running;
    logic         baseTick;
    ftpm_divsel_t divSel;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Prescaler mask: divisor minus one for settings 1, 2, 4, 8
    function automatic logic [2:0] div_mask(input ftpm_divsel_t sel);
        unique case (sel)
            2'd0: div_mask = 3'h0;
            2'd1: div_mask = 3'h1;
            2'd2: div_mask = 3'h3;
            2'd3: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    // Read decode shared by the register port
    function automatic ftpm_byte_t reg_read(input ftpm_mon_s s, input ftpm_addr_t a);
        unique case (a)
            `FTPM_OFS_CONFIG:     reg_read = s.cfg;
            `FTPM_OFS_DIVISOR:    reg_read = s.divCfg;
            `FTPM_OFS_FAN1_READ:  reg_read = s.read1;
            `FTPM_OFS_FAN2_READ:  reg_read = s.read2;
            `FTPM_OFS_FAN1_LIMIT: reg_read = s.limit1;
            `FTPM_OFS_FAN2_LIMIT: reg_read = s.limit2;
            default:              reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // ------------------------------------------------------------------------
    // Engine hookup
    // ------------------------------------------------------------------------
    // fan run follows start
    assign running = st_reg.cfg[`FTPM_CFG_START_BIT];
    assign meas.tachLevel = (st_reg.state == SEQ_FAN2) ? fan_two_pulse_input
                                                       : fan_one_pulse_input;
    assign divSel = (st_reg.state == SEQ_FAN2)
                  ? st_reg.divCfg[`FTPM_DIV2_LSB +: 2]
                  : st_reg.divCfg[`FTPM_DIV1_LSB +: 2];
    assign baseTick = (st_reg.baseCnt == 13'(BASE_DIV - 1));
    assign meas.tick  = baseTick && ((st_reg.preCnt & div_mask(divSel)) == div_mask(divSel));
    assign meas.start = st_reg.startPulse;
    assign meas.abort = ~running;

    assign regRdData     = st_reg.rdData;
    assign fanOneAlarm   = st_reg.alarm[0];
    assign fanTwoAlarm   = st_reg.alarm[1];
    assign monitorActive = meas.busy;

    ftpm_period_counter u_counter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .meas    (meas.counter)
    );

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        st_next            = st_reg;
        st_next.startPulse = 1'b0;

        // Time base: free divider of the system clock
        if (baseTick) begin
            st_next.baseCnt = 13'h0000;
        end else begin
            st_next.baseCnt = st_reg.baseCnt + 13'h0001;
        end
        // Prescaler restarts with each measurement so windows stay aligned
        if (st_reg.startPulse) begin
            st_next.preCnt = 3'h0;
        end else if (baseTick) begin
            st_next.preCnt = st_reg.preCnt + 3'h1;
        end

        // Sequencer: fan one, fan two, repeat while running
        unique case (st_reg.state)
            SEQ_IDLE: begin
                if (running) begin
                    st_next.state      = SEQ_FAN1;
                    st_next.startPulse = 1'b1;
                end
            end
            SEQ_FAN1: begin
                if (!running) begin
                    st_next.state = SEQ_IDLE;
                end else if (meas.done) begin
                    st_next.read1      = meas.count;
                    st_next.alarm[0]   = (meas.count > st_reg.limit1);
                    st_next.state      = SEQ_FAN2;
                    st_next.startPulse = 1'b1;
                end
            end
            SEQ_FAN2: begin
                if (!running) begin
                    st_next.state = SEQ_IDLE;
                end else if (meas.done) begin
                    st_next.read2      = meas.count;
                    st_next.alarm[1]   = (meas.count > st_reg.limit2);
                    st_next.state      = SEQ_FAN1;
                    st_next.startPulse = 1'b1;
                end
            end
            default: begin
                st_next.state = SEQ_IDLE;
            end
        endcase

        // Register reads: data is registered, one cycle after the strobe
        if (regRdEn) begin
            st_next.rdData = reg_read(st_reg, regAddr);
        end

        // Register writes; readings are read only
        if (regWrEn) begin
            unique case (regAddr)
                `FTPM_OFS_CONFIG: begin
                    if (regWrData[`FTPM_CFG_INIT_BIT]) begin
                        // Initialise: user registers back to defaults, bit clears
                        st_next.cfg    = `FTPM_RST_CONFIG;
                        st_next.divCfg = `FTPM_RST_DIVISOR;
                        st_next.limit1 = `FTPM_RST_LIMIT;
                        st_next.limit2 = `FTPM_RST_LIMIT;
                    end else begin
                        st_next.cfg = regWrData;
                    end
                end
                `FTPM_OFS_DIVISOR:    st_next.divCfg = regWrData;
                `FTPM_OFS_FAN1_LIMIT: st_next.limit1 = regWrData;
                `FTPM_OFS_FAN2_LIMIT: st_next.limit2 = regWrData;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg.cfg        <= `FTPM_RST_CONFIG;
            st_reg.divCfg     <= `FTPM_RST_DIVISOR;
            st_reg.read1      <= `FTPM_RST_READ;
            st_reg.read2      <= `FTPM_RST_READ;
            st_reg.limit1     <= `FTPM_RST_LIMIT;
            st_reg.limit2     <= `FTPM_RST_LIMIT;
            st_reg.alarm      <= 2'b00;
            st_reg.state      <= SEQ_IDLE;
            st_reg.baseCnt    <= 13'h0000;
            st_reg.preCnt     <= 3'h0;
            st_reg.startPulse <= 1'b0;
            st_reg.rdData     <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : ftpm_fan_tach_monitor

// [tb/ftpm_fan_tach_monitor_props.sv]
// Checker for the fan tach monitor: register port and status outputs.
// Assumes it is bound to the monitor top and sees only that module's ports.
`timescale 1ns/1ps
`include "ftpm_params.svh"
module ftpm_fan_tach_monitor_props #(
    parameter int unsigned BASE_DIV = 4
) (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 fan_one_pulse_input,
    input wire logic                 fan_two_pulse_input,
    input wire logic                 regWrEn,
    input wire logic                 regRdEn,
    input wire ftpm_pkg::ftpm_addr_t regAddr,
    input wire ftpm_pkg::ftpm_byte_t regWrData,
    input wire ftpm_pkg::ftpm_byte_t regRdData,
    input wire logic                 fanOneAlarm,
    input wire logic                 fanTwoAlarm,
    input wire logic                 monitorActive
);
    import ftpm_pkg::*;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Register port relations; antecedents match the bench's back-to-back access
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved without a read strobe");
    a_limit_back: assert property (regWrEn && regAddr == `FTPM_OFS_FAN1_LIMIT ##1
        regRdEn && !regWrEn && regAddr == `FTPM_OFS_FAN1_LIMIT |=> regRdData == $past(regWrData, 2))
        else $error("fan one limit did not read back");
    a_cfg_back: assert property (regWrEn && regAddr == `FTPM_OFS_CONFIG && !regWrData[7] ##1
        regRdEn && !regWrEn && regAddr == `FTPM_OFS_CONFIG |=> regRdData == $past(regWrData, 2))
        else $error("configuration did not read back");
    a_init_reload: assert property (regWrEn && regAddr == `FTPM_OFS_CONFIG && regWrData[7] ##1
        regRdEn && !regWrEn && regAddr == `FTPM_OFS_DIVISOR |=> regRdData == 8'h14)
        else $error("initialise did not restore the divisor");
    a_unmapped_zero: assert property (regRdEn && !(regAddr inside {8'h00, 8'h05, 8'h28,
        8'h29, 8'h3c, 8'h3d}) |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    // Monitoring start and halt as seen on the status output
    a_stop_idle: assert property (regWrEn && regAddr == `FTPM_OFS_CONFIG && !regWrData[0]
        |=> ##1 !monitorActive)
        else $error("measurement kept running after halt");
    a_start_arms: assert property (regWrEn && regAddr == `FTPM_OFS_CONFIG && regWrData[0]
        && !regWrData[7] && !monitorActive |-> ##[1:4] monitorActive)
        else $error("start did not arm a measurement");
    // Alarms only move on a completion, which needs an active window first
    a_alarm_quiet: assert property ((!monitorActive && !regWrEn)[*3]
        |=> $stable(fanOneAlarm) && $stable(fanTwoAlarm))
        else $error("alarm changed with no measurement");
endmodule : ftpm_fan_tach_monitor_props

bind ftpm_fan_tach_monitor ftpm_fan_tach_monitor_props #(.BASE_DIV(BASE_DIV)) props_u (
    .sys_clk(sys_clk), .rst(rst), .fan_one_pulse_input(fan_one_pulse_input),
    .fan_two_pulse_input(fan_two_pulse_input), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .fanOneAlarm(fanOneAlarm), .fanTwoAlarm(fanTwoAlarm), .monitorActive(monitorActive));

// [tb/ftpm_fan_model.sv]
// Fan tachometer model: square wave with a programmable half period.
// Assumes a pulled-up tach line, so the output idles high during reset.
`timescale 1ns/1ps
module ftpm_fan_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] halfPeriod,
    output logic             tachOut
);
    logic [15:0] phaseCnt;
    // Toggle every half period; >= keeps it sane when the period shrinks mid-run
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phaseCnt <= 16'h0000;
            tachOut  <= 1'b1;
        end else if (phaseCnt >= halfPeriod - 16'h0001) begin
            phaseCnt <= 16'h0000;
            tachOut  <= ~tachOut;
        end else begin
            phaseCnt <= phaseCnt + 16'h0001;
        end
    end
endmodule : ftpm_fan_model

// [tb/ftpm_fan_tach_monitor_tb.sv]
// Self-checking bench for the fan tach monitor: register tasks and two fan models.
// Assumes the design header, package, interface and modules are compiled first.
`timescale 1ns/1ps
`include "ftpm_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module ftpm_fan_tach_monitor_tb;
    import ftpm_pkg::*;
    logic        sys_clk;
    logic        rst = 1'b1;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    ftpm_addr_t  regAddr = 8'h00;
    ftpm_byte_t  regWrData = 8'h00;
    ftpm_byte_t  regRdData, rdVal, keepVal;
    logic        fanOne, fanTwo, fanOneAlarm, fanTwoAlarm, monitorActive;
    logic [15:0] halfOne = 16'h0064;
    logic [15:0] halfTwo = 16'h003c;
    int          bad_count = 0;
    int          n_tests = 0;
    ftpm_addr_t  tabAddr [6] = '{8'h05, 8'h00, 8'h3c, 8'h3d, 8'h28, 8'h29};
    ftpm_byte_t  tabVal [6] = '{8'h14, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};

    // Clock at 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Short time base so a tick is four clocks per divisor step
    ftpm_fan_tach_monitor #(.BASE_DIV(4)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .fan_one_pulse_input(fanOne),
        .fan_two_pulse_input(fanTwo), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .fanOneAlarm(fanOneAlarm), .fanTwoAlarm(fanTwoAlarm), .monitorActive(monitorActive));
    ftpm_fan_model fanOneU (.sys_clk(sys_clk), .rst(rst), .halfPeriod(halfOne), .tachOut(fanOne));
    ftpm_fan_model fanTwoU (.sys_clk(sys_clk), .rst(rst), .halfPeriod(halfTwo), .tachOut(fanTwo));

    // -------------------------------------------------------------------------
    // Register access: wr and rd own one cycle each, strobes set once per step
    // -------------------------------------------------------------------------
    task automatic wr(input ftpm_addr_t a, input ftpm_byte_t d);
        regWrEn <= 1'b1;
        regRdEn <= 1'b0;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        #1;
    endtask : wr

    task automatic rd(input ftpm_addr_t a, output ftpm_byte_t d);
        regRdEn <= 1'b1;
        regWrEn <= 1'b0;
        regAddr <= a;
        @(posedge sys_clk);
        #1 d = regRdData;
    endtask : rd

    task automatic idle(input int n);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic chk_regs(input int n);
        for (int i = 0; i < n; i++) begin
            rd(tabAddr[i], rdVal);
            `CHK("register value", tabVal[i], rdVal)
        end
    endtask : chk_regs

    // Count is ticks over two periods: 4h clocks over 4*2^c clocks per tick
    task automatic chk_fan(input ftpm_addr_t a, input int h, input int c, input int lim);
        int e;
        rd(a, rdVal);
        e = (h >> c) > 255 ? 255 : (h >> c);
        `CHK("fan count in range", 1'b1, (rdVal >= e - (e < 255) && rdVal <= e + 1))
        `CHK("fan alarm", (e > lim), (a == 8'h28 ? fanOneAlarm : fanTwoAlarm))
    endtask : chk_fan

    task automatic run_case(input int h1, input int c1, input int h2, input int c2);
        wr(`FTPM_OFS_CONFIG, 8'h00);
        wr(`FTPM_OFS_DIVISOR, ftpm_byte_t'((c2 << 4) | (c1 << 2)));
        halfOne <= 16'(h1);
        halfTwo <= 16'(h2);
        wr(`FTPM_OFS_CONFIG, 8'h01);
        rd(`FTPM_OFS_CONFIG, rdVal);
        `CHK("config start", 8'h01, rdVal)
        idle(6 * (h1 + h2) + 1300);
        chk_fan(8'h28, h1, c1, 40);
        chk_fan(8'h29, h2, c2, 20);
    endtask : run_case

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the roughly 24000 cycles the sequence needs
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk_regs(6);
        `CHK("alarms after reset", 2'b00, {fanOneAlarm, fanTwoAlarm})
        wr(`FTPM_OFS_FAN1_LIMIT, 8'd40);
        rd(`FTPM_OFS_FAN1_LIMIT, rdVal);
        `CHK("fan one limit", 8'd40, rdVal)
        wr(`FTPM_OFS_FAN2_LIMIT, 8'd20);
        rd(`FTPM_OFS_FAN2_LIMIT, rdVal);
        `CHK("fan two limit", 8'd20, rdVal)
        // Every divisor code on each fan, paired so alarms differ per case
        for (int c = 0; c < 4; c++) begin
            run_case(100, c, 60, 3 - c);
        end
        // Slow fan saturates the counter; window start may lag up to a period
        run_case(2000, 0, 60, 3);
        rd(`FTPM_OFS_FAN1_READ, rdVal);
        `CHK("fan one full scale", 8'hff, rdVal)
        wr(`FTPM_OFS_CONFIG, 8'h00);
        rd(`FTPM_OFS_FAN2_READ, keepVal);
        `CHK("halted window", 1'b0, monitorActive)
        halfTwo <= 16'd30;
        wr(`FTPM_OFS_FAN1_READ, 8'h5a);
        idle(1500);
        rd(`FTPM_OFS_FAN2_READ, rdVal);
        `CHK("reading frozen when halted", keepVal, rdVal)
        rd(`FTPM_OFS_FAN1_READ, rdVal);
        `CHK("reading ignores writes", 8'hff, rdVal)
        rd(8'h10, rdVal);
        `CHK("unmapped read", 8'h00, rdVal)
        wr(`FTPM_OFS_CONFIG, 8'h80);
        chk_regs(4);
        stop_test();
    end
endmodule : ftpm_fan_tach_monitor_tb
